// [common/gasalm_pkg.sv]
// Package with constants for the two-level gas alarm logic.
package gasalm_pkg;
    localparam int GASALM_CLK_HZ = 100_000_000;
    localparam int GASALM_DELAY_MS = 2000;
    localparam int GASALM_DELAY_CYC = GASALM_DELAY_MS * (GASALM_CLK_HZ / 1000);
    localparam int GASALM_FLASH_MS = 500;
    localparam int GASALM_FLASH_CYC = GASALM_FLASH_MS * (GASALM_CLK_HZ / 1000);
    localparam int GASALM_CNT_W = 32;
    localparam int GASALM_CONC_W = 16;
    localparam int GASALM_KEYS = 4;
endpackage

// [common/gasalm_lvl_if.sv]
// Interface carrying one alarm level between the top and a level unit.
`timescale 1ns/1ps
interface gasalm_lvl_if;
    logic raw;
    logic active;
    logic lamp;
    logic contact;
    modport unit (input raw, output active, output lamp, output contact);
    modport top (output raw, input active, input lamp, input contact);
endinterface

// [src/gasalm_level.sv]
// One alarm level: delay qualification, latching and lamp and contact drive.
`timescale 1ns/1ps
module gasalm_level
    import gasalm_pkg::*;
#(
    parameter int DELAY_CYC = GASALM_DELAY_CYC
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_reset,
    // Configuration and control.
    input wire logic i_latching,
    input wire logic i_cancel,
    input wire logic i_flash,
    // Level signals.
    gasalm_lvl_if.unit lvl
);
    typedef enum logic [1:0] {GASALM_IDLE, GASALM_ALARM, GASALM_ACKED} gasalm_st_t;
    typedef struct packed {
        gasalm_st_t st;
        logic [GASALM_CNT_W-1:0] cnt;
    } gasalm_lvl_t;
    gasalm_lvl_t s;
    gasalm_lvl_t next_s;

    // Qualification counter and alarm state machine.
    always_comb begin
        next_s = s;
        if (lvl.raw && s.cnt < GASALM_CNT_W'(DELAY_CYC)) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (!lvl.raw) begin
            next_s.cnt = '0;
        end
        unique case (s.st)
            GASALM_IDLE: begin
                if (lvl.raw && s.cnt >= GASALM_CNT_W'(DELAY_CYC) - 1'b1) begin
                    next_s.st = GASALM_ALARM;
                end
            end
            GASALM_ALARM: begin
                if (!i_latching && !lvl.raw) begin
                    next_s.st = GASALM_IDLE;
                end else if (i_cancel) begin
                    next_s.st = i_latching ? GASALM_ACKED : GASALM_IDLE;
                end
            end
            GASALM_ACKED: begin
                if (!lvl.raw) begin
                    next_s.st = GASALM_IDLE;
                end
            end
            // The unused fourth code falls back to idle rather than locking up.
            default: begin
                next_s.st = GASALM_IDLE;
            end
        endcase
        if (next_s.st == GASALM_IDLE && s.st != GASALM_IDLE) begin
            next_s.cnt = '0; // A cancelled alarm must requalify through the full delay.
        end
    end

    // State register.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            s <= '{st: GASALM_IDLE, cnt: '0};
        end else begin
            s <= next_s;
        end
    end

    // Outputs: flashing only while latched and not yet acknowledged.
    assign lvl.active = (s.st != GASALM_IDLE);
    assign lvl.contact = lvl.active;
    assign lvl.lamp = (s.st == GASALM_ACKED) || (s.st == GASALM_ALARM && (!i_latching || i_flash));
endmodule

// [src/gasalm_top.sv]
// Top of the two-level gas alarm decision logic.
`timescale 1ns/1ps
module gasalm_top
    import gasalm_pkg::*;
#(
    parameter int CONC_W = GASALM_CONC_W,
    parameter int DELAY_CYC = GASALM_DELAY_CYC,
    parameter int FLASH_CYC = GASALM_FLASH_CYC
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_reset,
    // Measurement and configuration.
    input wire logic [CONC_W-1:0] i_concentration,
    input wire logic [CONC_W-1:0] i_first_setpoint,
    input wire logic [CONC_W-1:0] i_second_setpoint,
    input wire logic i_latching,
    input wire logic i_low_lowlow_pattern,
    input wire logic i_detection_mode,
    // Front-panel keys: back, set, up, down.
    input wire logic [GASALM_KEYS-1:0] i_keys,
    // Lamps and contacts.
    output logic o_first_level_alarm_lamp,
    output logic o_second_level_alarm_lamp,
    output logic o_power_lamp,
    output logic o_first_level_alarm_contact,
    output logic o_second_level_alarm_contact
);
    typedef struct packed {
        logic [2:0] key1;
        logic [2:0] key2;
        logic [2:0] key3;
        logic [2:0] key4;
        logic keys_q;
        logic det_q;
        logic [GASALM_CNT_W-1:0] fcnt;
        logic flash;
        logic lamp1;
        logic lamp2;
        logic con1;
        logic con2;
    } gasalm_top_t;
    gasalm_top_t s;
    gasalm_top_t next_s;
    logic [GASALM_KEYS-1:0] key_now;
    logic cancel;
    gasalm_lvl_if l1 ();
    gasalm_lvl_if l2 ();

    // Threshold test, inverted for the low pattern.
    function automatic logic gasalm_trip(input logic [CONC_W-1:0] c, input logic [CONC_W-1:0] sp, input logic low);
        gasalm_trip = low ? (c <= sp) : (c >= sp);
    endfunction

    assign l1.raw = gasalm_trip(i_concentration, i_first_setpoint, i_low_lowlow_pattern);
    assign l2.raw = gasalm_trip(i_concentration, i_second_setpoint, i_low_lowlow_pattern);

    // Debounced key levels: a key counts once the second and third stages are both high.
    assign key_now = {s.key4[2] & s.key4[1], s.key3[2] & s.key3[1], s.key2[2] & s.key2[1], s.key1[2] & s.key1[1]};
    // A new key press in detection mode, or leaving detection mode, cancels.
    assign cancel = (s.det_q && (|key_now) && !s.keys_q) || (s.det_q && !i_detection_mode);

    // Synchronisers, flash timer and registered outputs.
    always_comb begin
        next_s = s;
        next_s.key1 = {s.key1[1:0], i_keys[0]};
        next_s.key2 = {s.key2[1:0], i_keys[1]};
        next_s.key3 = {s.key3[1:0], i_keys[2]};
        next_s.key4 = {s.key4[1:0], i_keys[3]};
        next_s.keys_q = |key_now;
        next_s.det_q = i_detection_mode;
        if (s.fcnt >= GASALM_CNT_W'(FLASH_CYC) - 1'b1) begin
            next_s.fcnt = '0;
            next_s.flash = !s.flash;
        end else begin
            next_s.fcnt = s.fcnt + 1'b1;
        end
        next_s.lamp1 = l1.lamp | l2.lamp;
        next_s.lamp2 = l2.lamp;
        next_s.con1 = l1.contact;
        next_s.con2 = l2.contact;
    end

    // State register.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Level units.
    gasalm_level #(.DELAY_CYC(DELAY_CYC)) u_lvl1 (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_latching(i_latching),
        .i_cancel(cancel),
        .i_flash(s.flash),
        .lvl(l1.unit)
    );
    gasalm_level #(.DELAY_CYC(DELAY_CYC)) u_lvl2 (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_latching(i_latching),
        .i_cancel(cancel),
        .i_flash(s.flash),
        .lvl(l2.unit)
    );

    assign o_first_level_alarm_lamp = s.lamp1;
    assign o_second_level_alarm_lamp = s.lamp2;
    assign o_power_lamp = 1'b1;
    assign o_first_level_alarm_contact = s.con1;
    assign o_second_level_alarm_contact = s.con2;
endmodule

// [testbench/gasalm_sensor.sv]
// Model of the gas sensor front end.
`timescale 1ns/1ps
module gasalm_sensor (
    // Clock and commanded gas level.
    input wire logic i_mclk,
    input wire logic [15:0] i_level,
    // Measured concentration.
    output logic [15:0] o_concentration
);
    // The sensor reports the ambient level one clock late.
    always_ff @(posedge i_mclk) begin
        o_concentration <= i_level;
    end
endmodule

// [testbench/gasalm_properties.sv]
// Port checker for the gas alarm top.
`timescale 1ns/1ps
module gasalm_properties
    import gasalm_pkg::*;
#(
    parameter int CONC_W = GASALM_CONC_W,
    parameter int DELAY_CYC = GASALM_DELAY_CYC
) (
    // Clock, reset and inputs.
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [CONC_W-1:0] i_concentration,
    input wire logic [CONC_W-1:0] i_first_setpoint,
    input wire logic i_latching,
    input wire logic i_low_lowlow_pattern,
    // Outputs.
    input wire logic o_first_level_alarm_lamp,
    input wire logic o_second_level_alarm_lamp,
    input wire logic o_power_lamp,
    input wire logic o_first_level_alarm_contact
);
    // Short names, the first level trip condition and how long it has held.
    wire l1 = o_first_level_alarm_lamp, c1 = o_first_level_alarm_contact, lat = i_latching;
    wire t1 = i_low_lowlow_pattern ? (i_concentration <= i_first_setpoint) : (i_concentration >= i_first_setpoint);
    logic [31:0] run;
    always_ff @(posedge i_mclk) begin
        run <= (i_reset || !t1) ? 32'h0 : run + 32'h1;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    sequence s_gone; (!lat && !t1)[*3]; endsequence
    sequence s_held; (lat && t1)[*3] ##1 (c1 && lat && t1); endsequence
    property p_pw; o_power_lamp; endproperty
    property p_rst; disable iff (1'b0) i_reset |=> !l1 && !c1 && !o_second_level_alarm_lamp; endproperty
    property p_two; o_second_level_alarm_lamp |-> l1; endproperty
    property p_dly; $rose(c1) |-> run >= DELAY_CYC; endproperty
    property p_open; s_gone |=> !c1; endproperty
    property p_hold; s_held |=> c1; endproperty
    property p_flash; $fell(l1) && c1 |-> ##[1:8] l1; endproperty
    property p_auto; !lat && !$past(lat) && !$past(lat, 2) |-> l1 == c1; endproperty
    a_pw: assert property (p_pw) else $error("power lamp");
    a_rst: assert property (p_rst) else $error("reset state");
    a_two: assert property (p_two) else $error("second lamp alone");
    a_dly: assert property (p_dly) else $error("early alarm");
    a_open: assert property (p_open) else $error("auto open");
    a_hold: assert property (p_hold) else $error("latch hold");
    a_flash: assert property (p_flash) else $error("flash");
    a_auto: assert property (p_auto) else $error("auto lamp");
endmodule
bind gasalm_top gasalm_properties #(.CONC_W(CONC_W), .DELAY_CYC(DELAY_CYC)) gasalm_properties_i (.*);

// [testbench/testbench.sv]
// Self-checking testbench for the gas alarm logic.
`timescale 1ns/1ps
module testbench;
    import gasalm_pkg::*;
    logic i_mclk = 0, i_reset = 1, lat = 0, low = 0, det = 1;
    logic [15:0] lvl = 16'h0000, sp2 = 16'h00c8, conc;
    logic [3:0] keys = 4'h0;
    wire l1, l2, pw, c1, c2;
    int n_errors = 0, cmp_count = 0;
    // Clock at 100 MHz.
    always #5 i_mclk = ~i_mclk;
    gasalm_sensor gasalm_sensor_i (.i_mclk(i_mclk), .i_level(lvl), .o_concentration(conc));
    gasalm_top #(.DELAY_CYC(10), .FLASH_CYC(4)) gasalm_top_i (.i_mclk(i_mclk), .i_reset(i_reset),
        .i_concentration(conc), .i_first_setpoint(16'h0064), .i_second_setpoint(sp2), .i_latching(lat),
        .i_low_lowlow_pattern(low), .i_detection_mode(det), .i_keys(keys), .o_first_level_alarm_lamp(l1),
        .o_second_level_alarm_lamp(l2), .o_power_lamp(pw), .o_first_level_alarm_contact(c1),
        .o_second_level_alarm_contact(c2));
    task tick(input int n); repeat (n) @(posedge i_mclk); #1; endtask
    task chk(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            $display("[FAIL] %s expected %b seen %b", n, e, g);
            n_errors++;
        end
    endtask
    task trip(input logic [15:0] v); lvl = v; tick(14); endtask
    task press(input int k); keys[k] = 1'b1; tick(7); keys = 4'h0; endtask
    task steady; repeat (8) begin chk("steady lamp", 1'b1, l1); tick(1); end endtask
    task flashes;
        logic p;
        int t;
        t = 0;
        p = l1;
        repeat (12) begin tick(1); t += (l1 !== p); p = l1; end
        chk("flashing", 1'b1, t > 1);
    endtask
    task summarize;
        if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Watchdog against a hung run.
    initial begin #20000; n_errors++; summarize(); end
    // Test sequence.
    initial begin
        tick(3); i_reset = 0; chk("power", 1'b1, pw);
        lvl = 16'h0096; tick(5); lvl = 16'h0032; tick(2); chk("short trip", 1'b0, c1);
        trip(16'h0096); chk("contact1", 1'b1, c1);
        chk("lamp2", 1'b0, l2);
        trip(16'h00c8); chk("lamp2 at setpoint", 1'b1, l2);
        chk("power in alarm", 1'b1, pw);
        lvl = 16'h0032; tick(3); chk("contact2 off", 1'b0, c2);
        trip(16'h0096); press(2); chk("key cancel", 1'b0, c1);
        lvl = 16'h0032; tick(4); lat = 1; trip(16'h0096); flashes();
        lvl = 16'h0032; tick(4); chk("latched", 1'b1, c1);
        flashes();
        press(0); chk("acked release", 1'b0, c1);
        trip(16'h0096); press(3); chk("acked contact held", 1'b1, c1);
        steady();
        lvl = 16'h0032; tick(3); chk("lamp off", 1'b0, l1);
        trip(16'h0096); det = 0; tick(6); steady();
        lvl = 16'h0032; det = 1; lat = 0; tick(4); low = 1; sp2 = 16'h001e;
        trip(16'h0064); chk("low contact1", 1'b1, c1);
        chk("low contact2", 1'b0, c2);
        lvl = 16'h0096; tick(3); chk("low release", 1'b0, c1);
        summarize();
    end
endmodule
